//--- logic/mam_bank.sv
// Purpose: alert mask, low-bit, config and overtemp status registers of a monitor
// Assumes: Avalon-MM slave, one request at a time, status inputs on this clock
// Notes:   overtemp pin is asynchronous and active low; two-flop synchronised
//
// What this block does
// - mask one bits 0,2,4,5,6 block alert for their voltage/temperature channels.
// - mask one bit 7 blocks alert for every second-status condition.
// - mask two bit 1 is read-only; when 1 it masks overtemp alerts.
// - mask two bits 2..5 block alert for fan one..four faults.
// - with speed input four as overtemp input, bit 5 masks timer events.
// - mask two bits 6,7 block alert for diode faults on remote one, two.
// - first low-bit register shows 2.5 V bits in 1:0, supply in 5:4.
// - second low-bit register shows remote one 3:2, local 5:4, remote two 7:6.
// - reading a low-bit register freezes it and its high bytes until read.
// - config three bit 0 turns the shared pin into the alert output.
// - config three bit 1 enables overtemp input monitoring, full_fan_on_overtemp and timer.
// - config three bit 2 runs all fans full while overtemp input asserted.
// - config three bit 3 speeds fan measurement from 1 s to 250 ms.
// - config three bits 4..7 make speed inputs one..four measure continuously.
// - once the lock bit is 1, config three ignores all writes.
// - status bit 0 sets on overtemp assertion and clears when read.
// - status bits 7:1 stay zero until assertion passes 45.52 ms.
// - past 45.52 ms status holds an 8-bit count in 22.76 ms steps.
// - assertion time beyond the limit raises the timer event; zero fires at once.
`timescale 1ns/100ps
`default_nettype none
module mam_bank #(
  parameter int unsigned STEP_CYCLES         = mam_pkg::STEP_CYCLES,
  parameter logic        OVERTEMP_MASK_VALUE = 1'b0
) (
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire logic [9:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  overtemp_input_n,
  input  wire logic                  speed_input_four_is_overtemp,
  input  wire mam_pkg::mam_cond_t    cond,
  input  wire mam_pkg::mam_reading_t readings,
  output logic                       alert_q,
  output logic                       overtemp_timer_event,
  output mam_pkg::mam_fan_ctl_t      fan_ctl_q
);
  logic [7:0]      mask1_q, mask2_q, cfg_q, status_q, limit_q;
  logic [7:0]      mask1_d, mask2_d, cfg_d, status_d, limit_d;
  logic            lock_q, lock_d;
  logic            ack_q;
  logic [4:0]      pend_q, pend_d;
  logic [4:0][9:0] reading_q;
  logic            ot_meta_q, ot_sync_q, ot_active_q;
  logic [7:0]      tsteps;
  logic            timer_exceed;
  logic [1:0][7:0] ext_b;
  logic            alert_d;
  mam_pkg::mam_fan_ctl_t fan_ctl_d;

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, the access acts at the release edge
  // ----------------------------------------------------------------
  wire req     = avs_read || avs_write;
  wire fire    = req && ack_q;
  wire rd_fire = fire && avs_read;
  wire wr_en   = fire && avs_write && avs_byteenable[0];
  wire [7:0] idx   = avs_address[9:2];
  wire [7:0] wdata = avs_writedata[7:0];
  assign avs_waitrequest = req && !ack_q;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire hit_m1   = (idx == mam_pkg::IDX_MASK_ONE);
  wire hit_m2   = (idx == mam_pkg::IDX_MASK_TWO);
  wire hit_vlo  = (idx == mam_pkg::IDX_VOLT_LO);
  wire hit_tlo  = (idx == mam_pkg::IDX_TEMP_LO);
  wire hit_cfg  = (idx == mam_pkg::IDX_CFG_3);
  wire hit_st   = (idx == mam_pkg::IDX_STATUS);
  wire hit_lim  = (idx == mam_pkg::IDX_LIMIT);
  wire hit_lock = (idx == mam_pkg::IDX_LOCK);
  wire [7:0] hi_off = idx - mam_pkg::IDX_HI_BASE;
  wire hit_hi   = (idx >= mam_pkg::IDX_HI_BASE) && (hi_off < 8'(mam_pkg::CH));
  wire [2:0] hi_ch = hi_off[2:0];

  // read-only overtemp mask bit always shows its fixed value
  wire [7:0] mask2_view = {mask2_q[7:2], OVERTEMP_MASK_VALUE, mask2_q[0]};

  // low bits of each channel placed in their register and lane
  always_comb
  begin
    ext_b = '0;
    for (int c = 0; c < mam_pkg::CH; c++)
      ext_b[mam_pkg::EXT_REG[c]][mam_pkg::EXT_POS[c] +: 2] = reading_q[c][1:0];
  end

  // read selection; unmapped words read zero
  wire [7:0] rd_byte = hit_m1   ? mask1_q
                     : hit_m2   ? mask2_view
                     : hit_vlo  ? ext_b[0]
                     : hit_tlo  ? ext_b[1]
                     : hit_cfg  ? cfg_q
                     : hit_st   ? status_q
                     : hit_lim  ? limit_q
                     : hit_lock ? {7'h00, lock_q}
                     : hit_hi   ? reading_q[hi_ch][9:2]
                     : mam_pkg::RST_BYTE;

  // ----------------------------------------------------------------
  // register write paths
  // ----------------------------------------------------------------
  assign mask1_d = (wr_en && hit_m1) ? wdata : mask1_q;
  assign mask2_d = (wr_en && hit_m2) ? (wdata & mam_pkg::M2_WMASK) : mask2_q;
  assign cfg_d   = (wr_en && hit_cfg && !lock_q) ? wdata : cfg_q;
  assign limit_d = (wr_en && hit_lim) ? wdata : limit_q;
  // lock can only be set; it falls again only at reset
  assign lock_d  = lock_q || (wr_en && hit_lock && wdata[mam_pkg::LOCK_BIT]);

  // ----------------------------------------------------------------
  // coherent readings: freeze per group until its high bytes are read
  // ----------------------------------------------------------------
  wire [4:0] hi_clr = (rd_fire && hit_hi) ? 5'(5'h01 << hi_ch) : 5'h00;
  assign pend_d = (pend_q & ~hi_clr)
                | ((rd_fire && hit_vlo) ? mam_pkg::GRP_VOLT : 5'h00)
                | ((rd_fire && hit_tlo) ? mam_pkg::GRP_TEMP : 5'h00);

  for (genvar c = 0; c < mam_pkg::CH; c++)
  begin : g_ch
    // a whole group stays put, so low and high bits match unless new results arrive in the low-bit read's two bus cycles
    wire frozen = |(pend_q & mam_pkg::CH_GROUP[c]);
    always_ff @(posedge clock)
    begin
      if (sys_rst)
        reading_q[c] <= '0;
      else if (readings.valid && !frozen)
        reading_q[c] <= readings.value[c];
    end
  end

  // ----------------------------------------------------------------
  // overtemp input: synchroniser, monitoring and duration status
  // ----------------------------------------------------------------
  wire ot_active = cfg_q[mam_pkg::CFG_MON] && !ot_sync_q;
  wire ot_new    = ot_active && !ot_active_q;
  wire load_cnt  = ot_active && (tsteps >= mam_pkg::REPORT_STEPS);
  // set beats a read clear in the same cycle; a set at a read's wait edge is still cleared unseen
  assign status_d = ot_new    ? mam_pkg::STATUS_SEEN
                  : load_cnt  ? tsteps
                  : (rd_fire && hit_st) ? mam_pkg::RST_BYTE
                  : status_q;

  mam_overtemp_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_timer (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .active   (ot_active),
    .limit    (limit_q),
    .steps_q  (tsteps),
    .exceed_q (timer_exceed)
  );
  assign overtemp_timer_event = timer_exceed;

  // ----------------------------------------------------------------
  // alert combine: masked per source, second status gated as a group
  // ----------------------------------------------------------------
  wire fan4_src = speed_input_four_is_overtemp ? timer_exceed : cond.status_two[mam_pkg::M2_FAN4];
  wire [7:0] s2_src  = {cond.status_two[7:6], fan4_src, cond.status_two[4:0]};
  wire [7:0] s1_live = cond.status_one & ~mask1_q & mam_pkg::S1_USED;
  wire [7:0] s2_live = s2_src & ~mask2_view & mam_pkg::S2_USED;
  assign alert_d = (|s1_live) || ((|s2_live) && !mask1_q[mam_pkg::M1_GROUP]);

  // ----------------------------------------------------------------
  // fan and pin controls, registered so outputs are glitch free
  // ----------------------------------------------------------------
  assign fan_ctl_d.alert_pin_mode   = cfg_q[mam_pkg::CFG_ALERT];
  assign fan_ctl_d.fans_full        = ot_active && cfg_q[mam_pkg::CFG_FULL_FAN_ON_OVERTEMP];
  assign fan_ctl_d.fast_speed       = cfg_q[mam_pkg::CFG_FAST];
  assign fan_ctl_d.continuous_speed = cfg_q[mam_pkg::CFG_CONT +: 4];

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    ot_meta_q <= overtemp_input_n;
    ot_sync_q <= ot_meta_q;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      mask1_q      <= mam_pkg::RST_BYTE;
      mask2_q      <= mam_pkg::RST_BYTE;
      cfg_q        <= mam_pkg::RST_BYTE;
      status_q     <= mam_pkg::RST_BYTE;
      limit_q      <= mam_pkg::RST_BYTE;
      lock_q       <= 1'b0;
      pend_q       <= 5'h00;
      ack_q        <= 1'b0;
      ot_active_q  <= 1'b0;
      alert_q      <= 1'b0;
      fan_ctl_q    <= '0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      mask1_q    <= mask1_d;
      mask2_q    <= mask2_d;
      cfg_q      <= cfg_d;
      status_q   <= status_d;
      limit_q    <= limit_d;
      lock_q     <= lock_d;
      pend_q     <= pend_d;
      ack_q      <= req && !ack_q;
      ot_active_q <= ot_active;
      alert_q    <= alert_d;
      fan_ctl_q  <= fan_ctl_d;
      if (avs_read && !ack_q)
        avs_readdata <= 32'(rd_byte);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chan_alert_a: assert property (@(posedge clock) disable iff (sys_rst)
    (|(cond.status_one & ~mask1_q & mam_pkg::S1_USED)) |=> alert_q)
    else $error("unmasked channel did not raise alert");
  group_mask_a: assert property (@(posedge clock) disable iff (sys_rst)
    (mask1_q[mam_pkg::M1_GROUP] && !(|(cond.status_one & ~mask1_q & mam_pkg::S1_USED))) |=> !alert_q)
    else $error("group mask let alert through");
  overtemp_fixed_a: assert property (@(posedge clock) disable iff (sys_rst)
    (avs_read && !ack_q && hit_m2) |=> avs_readdata[mam_pkg::M2_OVERTEMP] == OVERTEMP_MASK_VALUE)
    else $error("read-only mask bit read back wrong");
  fan_alert_a: assert property (@(posedge clock) disable iff (sys_rst)
    (!mask1_q[mam_pkg::M1_GROUP] && cond.status_two[mam_pkg::M2_FAN_ONE] && !mask2_q[mam_pkg::M2_FAN_ONE]) |=> alert_q)
    else $error("fan fault did not raise alert");
  timer_alert_a: assert property (@(posedge clock) disable iff (sys_rst)
    (speed_input_four_is_overtemp && timer_exceed && !mask1_q[mam_pkg::M1_GROUP] && !mask2_q[mam_pkg::M2_FAN4])
    |=> alert_q)
    else $error("timer event did not raise alert");
  diode_alert_a: assert property (@(posedge clock) disable iff (sys_rst)
    (!mask1_q[mam_pkg::M1_GROUP] && cond.status_two[mam_pkg::M2_DIODE_ONE] && !mask2_q[mam_pkg::M2_DIODE_ONE])
    |=> alert_q)
    else $error("diode fault did not raise alert");
  freeze_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    (pend_q[0] && readings.valid) |=> $stable(reading_q[0]))
    else $error("frozen reading was replaced");
  lock_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    (lock_q && wr_en && hit_cfg) |=> $stable(cfg_q))
    else $error("locked config accepted a write");
  full_fan_on_overtemp_fans_a: assert property (@(posedge clock) disable iff (sys_rst)
    (ot_active && cfg_q[mam_pkg::CFG_FULL_FAN_ON_OVERTEMP]) |=> fan_ctl_q.fans_full)
    else $error("full_fan_on_overtemp did not run fans full");
  seen_flag_a: assert property (@(posedge clock) disable iff (sys_rst)
    ot_new |=> status_q == mam_pkg::STATUS_SEEN)
    else $error("assertion flag not set cleanly");
  read_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    (rd_fire && hit_st && !ot_active) |=> status_q == mam_pkg::RST_BYTE)
    else $error("status not cleared by read");
  bus_wait_a: assert property (@(posedge clock) disable iff (sys_rst)
    (req && !ack_q) |-> avs_waitrequest ##1 (!req || !avs_waitrequest))
    else $error("waitrequest did not release after one cycle");

  alert_seen_c:  cover property (@(posedge clock) disable iff (sys_rst) $rose(alert_q));
  freeze_done_c: cover property (@(posedge clock) disable iff (sys_rst) $fell(pend_q[4]));
  timer_fire_c:  cover property (@(posedge clock) disable iff (sys_rst) $rose(timer_exceed));
endmodule
`default_nettype wire

//--- logic/mam_overtemp_timer.sv
// Purpose: times overtemp input assertion in 22.76 ms steps and flags limit overrun
// Assumes: active is already synchronised and gated by the monitor enable
// Notes:   steps saturate at full scale rather than wrap
`timescale 1ns/100ps
`default_nettype none
module mam_overtemp_timer #(
  parameter int unsigned STEP_CYCLES = mam_pkg::STEP_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       active,
  input  wire logic [7:0] limit,
  output logic      [7:0] steps_q,
  output logic            exceed_q
);
  localparam int unsigned CW = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(STEP_CYCLES - 1);

  if (STEP_CYCLES < 1 || STEP_CYCLES > 32'h0100_0000)
  begin : g_bad_step
    $error("step length out of range");
  end

  logic [CW-1:0] cyc_q;
  logic [CW-1:0] cyc_d;
  logic [7:0]    steps_d;
  logic          exceed_d;

  // ----------------------------------------------------------------
  // step counting
  // ----------------------------------------------------------------
  wire step_done = active && (cyc_q == LAST);
  wire at_max    = (steps_q == mam_pkg::STEPS_MAX);
  assign cyc_d    = (!active || step_done) ? '0 : cyc_q + 1'b1;
  assign steps_d  = !active ? '0 : (step_done && !at_max) ? steps_q + 8'h01 : steps_q;
  // zero limit fires at once; otherwise whole steps beyond the limit
  assign exceed_d = active && (limit == mam_pkg::LIMIT_NOW || steps_q > limit);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cyc_q    <= '0;
      steps_q  <= '0;
      exceed_q <= 1'b0;
    end
    else
    begin
      cyc_q    <= cyc_d;
      steps_q  <= steps_d;
      exceed_q <= exceed_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  step_count_a: assert property (@(posedge clock) disable iff (sys_rst)
    (active && cyc_q == LAST && !at_max) |=> steps_q == $past(steps_q) + 8'h01)
    else $error("step count did not advance");
  zero_limit_a: assert property (@(posedge clock) disable iff (sys_rst)
    (active && limit == mam_pkg::LIMIT_NOW) |=> exceed_q)
    else $error("zero limit did not fire at once");
  below_limit_a: assert property (@(posedge clock) disable iff (sys_rst)
    (!active || (limit != mam_pkg::LIMIT_NOW && steps_q <= limit)) |=> !exceed_q)
    else $error("timer event raised below limit");
endmodule
`default_nettype wire

//--- logic/mam_pkg.sv
// Purpose: shared constants and carriers for the alert mask / overtemp timer bank
// Assumes: 100 MHz clock, 8-bit registers each in one 32-bit Avalon word
// Notes:   byte address of a register is four times its index
`default_nettype none
package mam_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned STEP_TIME_NS   = 22_760_000;   // 22.76 ms
  localparam int unsigned REPORT_TIME_NS = 45_520_000;   // 45.52 ms
  localparam int unsigned STEP_CYCLES    = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  REPORT_STEPS   = 8'(REPORT_TIME_NS / STEP_TIME_NS);
  localparam logic [7:0]  STEPS_MAX      = 8'hff;
  localparam logic [7:0]  LIMIT_NOW      = 8'h00;

  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MASK_ONE = 8'h74;
  localparam logic [7:0] IDX_MASK_TWO = 8'h75;
  localparam logic [7:0] IDX_VOLT_LO  = 8'h76;
  localparam logic [7:0] IDX_TEMP_LO  = 8'h77;
  localparam logic [7:0] IDX_CFG_3    = 8'h78;
  localparam logic [7:0] IDX_STATUS   = 8'h79;
  localparam logic [7:0] IDX_LIMIT    = 8'h7a;
  localparam logic [7:0] IDX_LOCK     = 8'h7c;
  localparam logic [7:0] IDX_HI_BASE  = 8'h20;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] STATUS_SEEN  = 8'h01;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] S1_USED    = 8'h75;  // 2.5 V, supply, remote one, local, remote two
  localparam logic [7:0] S2_USED    = 8'hfe;
  localparam logic [7:0] M2_WMASK   = 8'hfd;  // bit 1 cannot be written
  localparam int         M1_GROUP   = 7;
  localparam int         M2_OVERTEMP  = 1;
  localparam int         M2_FAN_ONE   = 2;
  localparam int         M2_FAN4      = 5;
  localparam int         M2_DIODE_ONE = 6;
  localparam int         CFG_ALERT  = 0;
  localparam int         CFG_MON    = 1;
  localparam int         CFG_FULL_FAN_ON_OVERTEMP  = 2;
  localparam int         CFG_FAST   = 3;
  localparam int         CFG_CONT   = 4;
  localparam int         LOCK_BIT   = 0;
  localparam int         CH         = 5;
  localparam int         EXT_REG [CH] = '{0, 0, 1, 1, 1};
  localparam int         EXT_POS [CH] = '{0, 4, 2, 4, 6};
  localparam logic [4:0] CH_GROUP [CH] = '{5'h03, 5'h03, 5'h1c, 5'h1c, 5'h1c};
  localparam logic [4:0] GRP_VOLT = 5'h03;
  localparam logic [4:0] GRP_TEMP = 5'h1c;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic            valid;   // one-cycle strobe: new conversion results
    logic [4:0][9:0] value;   // 2.5 V, supply, remote one, local, remote two
  } mam_reading_t;

  typedef struct packed {
    logic [7:0] status_one;
    logic [7:0] status_two;
  } mam_cond_t;

  typedef struct packed {
    logic       alert_pin_mode;
    logic       fans_full;
    logic       fast_speed;
    logic [3:0] continuous_speed;
  } mam_fan_ctl_t;
endpackage
`default_nettype wire

//--- sim/mam_testbench.sv
// Purpose: self-checking bench for the alert mask, low-bit and overtemp timer bank
// Assumes: one bus request at a time; the timer step is shortened to 8 cycles
// Notes:   random masks and conditions come from a fixed seed, so runs repeat
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int unsigned STEP = 8;
  logic                  clock          = 1'b0;
  logic                  sys_rst        = 1'b1;
  logic [9:0]            avs_address    = '0;
  logic                  avs_read       = 1'b0;
  logic                  avs_write      = 1'b0;
  logic [31:0]           avs_writedata  = '0;
  logic [3:0]            avs_byteenable = 4'hf;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic                  overtemp_n     = 1'b1;
  logic                  sp4            = 1'b0;
  mam_pkg::mam_cond_t    cond           = '0;
  mam_pkg::mam_reading_t rdg            = '0;
  logic                  alert_q;
  logic                  tev;
  mam_pkg::mam_fan_ctl_t fan_ctl_q;
  int                    failures       = 0;
  int                    comparisons    = 0;
  int                    seed           = 91;
  logic [31:0]           rd;
  logic [7:0]            m1;
  logic [7:0]            m2;
  mam_pkg::mam_reading_t old;
  localparam logic [7:0] IDS [6] = '{8'h74, 8'h75, 8'h78, 8'h79, 8'h7a, 8'h7f};

  mam_bank #(.STEP_CYCLES(STEP)) dut_u (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .overtemp_input_n(overtemp_n), .speed_input_four_is_overtemp(sp4), .cond(cond), .readings(rdg),
    .alert_q(alert_q), .overtemp_timer_event(tev), .fan_ctl_q(fan_ctl_q));

  // free-running 100 MHz clock
  always #5 clock = ~clock;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge; read data taken at that edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clock);
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h00_0000, d};
    do
      @(posedge clock);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(name, rd, {24'h00_0000, exp});
  endtask

  // one strobe of fresh conversion results
  task automatic push();
    @(posedge clock);
    rdg.valid <= 1'b1;
    for (int c = 0; c < 5; c++) rdg.value[c] <= 10'($random(seed));
    @(posedge clock);
    rdg.valid <= 1'b0;
  endtask

  // expected alert: overtemp mask bit reads 0, status_two bit 0 unused
  function automatic logic exp_alert(input logic [7:0] a, input logic [7:0] b,
                                     input logic [7:0] s1, input logic [7:0] s2);
    return (|(s1 & ~a & 8'h75)) | (~a[7] & (|(s2 & ~(b & 8'hfd) & 8'hfe)));
  endfunction

  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog: the whole sequence needs a few hundred cycles
  initial
  begin
    #200000;
    failures++;
    finish_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd_chk("reset value", IDS[i], 8'h00);
    $display("test reset values done");
    // random masks against random conditions; first half keeps the group path open
    for (int i = 0; i < 16; i++)
    begin
      m1 = 8'($random(seed));
      m2 = 8'($random(seed));
      if (i < 8) m1[7] = 1'b0;
      bus(1'b1, 8'h74, m1);
      bus(1'b1, 8'h75, m2);
      rd_chk("mask one", 8'h74, m1);
      rd_chk("mask two", 8'h75, m2 & 8'hfd);
      cond <= 16'($random(seed));
      repeat (3) @(posedge clock);
      check("alert", alert_q, exp_alert(m1, m2, cond.status_one, cond.status_two));
    end
    $display("test alert masking done");
    // config three mirrors on the fan controls while the pin is idle
    for (int i = 0; i < 4; i++)
    begin
      m1 = 8'($random(seed));
      bus(1'b1, 8'h78, m1);
      rd_chk("config three", 8'h78, m1);
      check("fan ctl", fan_ctl_q, {m1[0], 1'b0, m1[3], m1[7:4]});
    end
    $display("test config three done");
    // freeze: new results must not replace a group until its high bytes are read
    push();
    old = rdg;
    rd_chk("volt low", 8'h76, {2'b00, old.value[1][1:0], 2'b00, old.value[0][1:0]});
    push();
    rd_chk("volt high", 8'h20, old.value[0][9:2]);
    rd_chk("supply high", 8'h21, old.value[1][9:2]);
    push();
    old = rdg;
    rd_chk("temp low", 8'h77, {old.value[4][1:0], old.value[3][1:0], old.value[2][1:0], 2'b00});
    push();
    for (int c = 2; c < 5; c++) rd_chk("temp high", 8'h20 + 8'(c), old.value[c][9:2]);
    old = rdg;
    rd_chk("volt high live", 8'h20, old.value[0][9:2]);
    $display("test low bits done");
    // overtemp: monitor and full_fan_on_overtemp on, limit zero then three, timer event routed to fan four bit
    cond <= '0;
    sp4  <= 1'b1;
    bus(1'b1, 8'h74, 8'h00);
    bus(1'b1, 8'h75, 8'h00);
    bus(1'b1, 8'h7a, 8'h00);
    bus(1'b1, 8'h78, 8'h06);
    overtemp_n <= 1'b0;
    repeat (6) @(posedge clock);
    check("event at once", tev, 1'b1);
    check("full_fan_on_overtemp", fan_ctl_q.fans_full, 1'b1);
    overtemp_n <= 1'b1;
    bus(1'b1, 8'h7a, 8'h03);
    rd_chk("status held", 8'h79, 8'h01);
    rd_chk("status cleared", 8'h79, 8'h00);
    overtemp_n <= 1'b0;
    repeat (6) @(posedge clock);
    rd_chk("status seen", 8'h79, 8'h01);
    check("event early", tev, 1'b0);
    repeat (60) @(posedge clock);
    bus(1'b0, 8'h79, 8'h00);
    check("count range", 32'(rd[7:0] >= 8'h06 && rd[7:0] <= 8'h0a), 1);
    check("event late", tev, 1'b1);
    check("alert timer", alert_q, 1'b1);
    bus(1'b1, 8'h75, 8'h20);
    repeat (3) @(posedge clock);
    check("alert timer masked", alert_q, 1'b0);
    overtemp_n <= 1'b1;
    repeat (6) @(posedge clock);
    check("full_fan_on_overtemp off", fan_ctl_q.fans_full, 1'b0);
    $display("test overtemp timer done");
    // byte enable off and the lock both leave config three untouched
    bus(1'b1, 8'h78, 8'h5a);
    avs_byteenable <= 4'h0;
    bus(1'b1, 8'h78, 8'hff);
    avs_byteenable <= 4'hf;
    rd_chk("byte enable", 8'h78, 8'h5a);
    bus(1'b1, 8'h7c, 8'h01);
    bus(1'b1, 8'h78, 8'ha5);
    rd_chk("locked", 8'h78, 8'h5a);
    $display("test lock done");
    finish_test();
  end
endmodule
`default_nettype wire
